// *** rtl/caod_pkg.sv ***
// package for the arithmetic/logic opcode decoder: opcodes, selectors, cycle counts
// assumes a single 20 MHz processor clock domain
package caod_pkg;

	localparam logic [7:0] OP_PAIR_ADD_MASK = 8'hcf;
	localparam logic [7:0] OP_PAIR_ADD = 8'h09;
	localparam logic [4:0] OP_SUB_REG = 5'h12;
	localparam logic [4:0] OP_SBB_REG = 5'h13;
	localparam logic [4:0] OP_AND_REG = 5'h14;
	localparam logic [4:0] OP_XOR_REG = 5'h15;
	localparam logic [4:0] OP_OR_REG = 5'h16;
	localparam logic [4:0] OP_CMP_REG = 5'h17;
	localparam logic [7:0] OP_SUB_IMM = 8'hd6;
	localparam logic [7:0] OP_SBB_IMM = 8'hde;
	localparam logic [7:0] OP_AND_IMM = 8'he6;
	localparam logic [7:0] OP_XOR_IMM = 8'hee;
	localparam logic [7:0] OP_OR_IMM = 8'hf6;
	localparam logic [7:0] OP_CMP_IMM = 8'hfe;
	localparam logic [7:0] OP_ROT_LEFT = 8'h07;
	localparam logic [7:0] OP_ROT_RIGHT = 8'h0f;
	localparam logic [7:0] OP_ROT_LEFT_CY = 8'h17;
	localparam logic [7:0] OP_ROT_RIGHT_CY = 8'h1f;

	localparam logic [2:0] SEL_B = 3'h0;
	localparam logic [2:0] SEL_C = 3'h1;
	localparam logic [2:0] SEL_D = 3'h2;
	localparam logic [2:0] SEL_E = 3'h3;
	localparam logic [2:0] SEL_H = 3'h4;
	localparam logic [2:0] SEL_L = 3'h5;
	localparam logic [2:0] SEL_MEM = 3'h6;
	localparam logic [2:0] SEL_ACC = 3'h7;

	localparam logic [3:0] CYC_REG = 4'h4;
	localparam logic [3:0] CYC_MEM = 4'h7;
	localparam logic [3:0] CYC_PAIR = 4'ha;
	localparam logic [3:0] CYC_COND_SHORT = 4'h6;
	localparam logic [3:0] CYC_COND_LONG = 4'hc;

	typedef enum logic [3:0] {
		CAOD_NONE, CAOD_PAIR_ADD, CAOD_SUB, CAOD_SBB, CAOD_AND, CAOD_XOR, CAOD_OR,
		CAOD_CMP, CAOD_RLC, CAOD_RRC, CAOD_RAL, CAOD_RAR, CAOD_COND
	} caod_op_e;

	typedef enum logic [1:0] {
		CAOD_SRC_REG, CAOD_SRC_MEM, CAOD_SRC_IMM, CAOD_SRC_PAIR
	} caod_src_e;

	typedef enum logic [1:0] {CAOD_IDLE, CAOD_BUSY} caod_st_e;

	// decoded instruction as presented to the datapath
	typedef struct packed {
		caod_op_e op;
		caod_src_e src;
		logic [2:0] reg_sel;
		logic [1:0] pair_sel;
		logic writes_acc;
		logic writes_flags;
		logic use_borrow;
		logic [3:0] states;
	} caod_dec_s;

	typedef struct packed {
		caod_st_e st;
		logic [3:0] count;
		caod_dec_s dec;
		logic valid;
		logic busy;
		logic done;
		logic illegal;
	} caod_state_s;

endpackage

// *** rtl/caod_decoder.sv ***
// opcode decode and clock-state accounting for the arithmetic/logic subset
// one opcode is held in decode while its clock states are counted down
// assumes opcode strobe and condition result come from logic on the same clock
// assumes the datapath fetches memory and immediate operands itself
//
// What this block does
// RQ1: selector codes B,C,D,E,H,L,memory via HL,accumulator are 000 through 111.
// RQ2: 00pp1001 adds pair BC, DE, HL or SP into HL in 10 states.
// RQ3: 10010sss subtracts register, 10011sss also subtracts borrow; 4 states each.
// RQ4: selector 110 on subtract forms reads memory at HL; 7 states.
// RQ5: 11010110 subtracts immediate, 11011110 with borrow; 7 states.
// RQ6: AND, XOR, OR, compare register groups decode at 10100..10111; 4 states.
// RQ7: selector 110 on logic groups reads memory at HL; 7 states.
// RQ8: immediate AND, XOR, OR, compare at e6, ee, f6, fe; 7 states.
// RQ9: rotates left, right, left/right through carry at 07,0f,17,1f; 4 states.
// RQ10: conditional instructions take short or long count by condition result.
// RQ11: compare sets flags like subtract but leaves accumulator unchanged.
module caod_decoder
	import caod_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	// opcode in
	input wire logic op_valid,
	input wire logic [7:0] opcode,
	// conditional instruction from the rest of the decoder
	input wire logic cond_instr,
	input wire logic cond_met,
	// decode out
	output caod_dec_s dec,
	output logic dec_valid,
	output logic dec_illegal,
	output logic busy,
	output logic done
);

	caod_state_s r;
	caod_state_s next_r;
	caod_dec_s d;

	// family members in matching order: code table and the op it selects
	localparam int ALU_N = 6;
	localparam int ROT_N = 4;
	localparam logic [4:0] ALU_REG_CODE [ALU_N] = '{
		OP_SUB_REG,
		OP_SBB_REG,
		OP_AND_REG,
		OP_XOR_REG,
		OP_OR_REG,
		OP_CMP_REG
	};

	localparam logic [7:0] ALU_IMM_CODE [ALU_N] = '{
		OP_SUB_IMM,
		OP_SBB_IMM,
		OP_AND_IMM,
		OP_XOR_IMM,
		OP_OR_IMM,
		OP_CMP_IMM
	};

	localparam caod_op_e ALU_OP [ALU_N] = '{
		CAOD_SUB,
		CAOD_SBB,
		CAOD_AND,
		CAOD_XOR,
		CAOD_OR,
		CAOD_CMP
	};

	localparam logic [7:0] ROT_CODE [ROT_N] = '{
		OP_ROT_LEFT,
		OP_ROT_RIGHT,
		OP_ROT_LEFT_CY,
		OP_ROT_RIGHT_CY
	};

	localparam caod_op_e ROT_OP [ROT_N] = '{
		CAOD_RLC,
		CAOD_RRC,
		CAOD_RAL,
		CAOD_RAR
	};

	// one match line per family member
	logic [ALU_N-1:0] alu_reg_hit;
	logic [ALU_N-1:0] alu_imm_hit;
	logic [ROT_N-1:0] rot_hit;
	logic pair_add_hit;
	logic sel_mem;
	logic alu_reg_any;
	logic alu_imm_any;
	logic rot_any;

	for (genvar gi = 0; gi < ALU_N; gi++) begin : g_match
		assign alu_reg_hit[gi] = (opcode[7:3] == ALU_REG_CODE[gi]); // [RQ3] [RQ6]
		assign alu_imm_hit[gi] = (opcode == ALU_IMM_CODE[gi]); // [RQ5] [RQ8]
		if (gi < ROT_N) begin : g_rot
			assign rot_hit[gi] = (opcode == ROT_CODE[gi]); // [RQ9]
		end
	end

	// pp picks the pair; the rest of the byte is fixed
	assign pair_add_hit = ((opcode & OP_PAIR_ADD_MASK) == OP_PAIR_ADD); // [RQ2]
	assign sel_mem = (opcode[2:0] == SEL_MEM); // [RQ4] [RQ7]
	assign alu_reg_any = |alu_reg_hit;
	assign alu_imm_any = |alu_imm_hit;
	assign rot_any = |rot_hit;

	// an opcode is only looked at between instructions
	logic take;
	logic last_state;
	assign take = op_valid && (r.st == CAOD_IDLE);
	assign last_state = (r.count == 4'h1);

	// combinational decode of the offered opcode
	always_comb begin
		d = '0;
		d.op = CAOD_NONE;
		d.src = CAOD_SRC_REG;
		d.reg_sel = opcode[2:0]; // [RQ1]
		d.pair_sel = opcode[5:4];
		// conditional timing wins: the byte then belongs to another family
		if (cond_instr) begin
			d.op = CAOD_COND;
			d.states = cond_met ? CYC_COND_LONG : CYC_COND_SHORT; // [RQ10]
		end else if (pair_add_hit) begin
			d.op = CAOD_PAIR_ADD; // [RQ2]
			d.src = CAOD_SRC_PAIR;
			d.writes_flags = 1'b1;
			d.states = CYC_PAIR;
		end else if (alu_reg_any) begin
			for (int i = 0; i < ALU_N; i++) begin
				if (alu_reg_hit[i]) begin
					d.op = ALU_OP[i]; // [RQ3] [RQ6]
				end
			end
			if (sel_mem) begin
				d.src = CAOD_SRC_MEM; // [RQ4] [RQ7]
				d.states = CYC_MEM;
			end else begin
				d.states = CYC_REG;
			end
		end else if (alu_imm_any) begin
			d.src = CAOD_SRC_IMM;
			d.states = CYC_MEM; // [RQ5] [RQ8]
			for (int i = 0; i < ALU_N; i++) begin
				if (alu_imm_hit[i]) begin
					d.op = ALU_OP[i]; // [RQ5] [RQ8]
				end
			end
		end else if (rot_any) begin
			// rotates act on the accumulator whatever the low bits say
			d.reg_sel = SEL_ACC;
			d.states = CYC_REG; // [RQ9]
			for (int i = 0; i < ROT_N; i++) begin
				if (rot_hit[i]) begin
					d.op = ROT_OP[i]; // [RQ9]
				end
			end
		end
		// anything else stays none with zero states and is reported illegal
		if (d.op != CAOD_NONE && d.op != CAOD_COND && d.op != CAOD_PAIR_ADD) begin
			d.writes_flags = 1'b1;
			// compare only sets flags
			d.writes_acc = (d.op != CAOD_CMP); // [RQ11]
		end
		d.use_borrow = (d.op inside {CAOD_SBB, CAOD_RAL, CAOD_RAR});
	end

	// one instruction at a time; count down its clock states
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.valid = 1'b0;
		next_r.illegal = 1'b0;
		case (r.st)
			CAOD_IDLE: begin
				if (take) begin
					next_r.dec = d;
					if (d.op == CAOD_NONE) begin
						// unknown byte: flag it and stay idle, no done follows
						next_r.illegal = 1'b1;
					end else begin
						next_r.valid = 1'b1;
						// first state spent in this cycle
						next_r.count = d.states - 4'h1;
						next_r.st = CAOD_BUSY;
						next_r.busy = 1'b1;
					end
				end
			end
			CAOD_BUSY: begin
				// done shows in the cycle after the last state
				if (last_state) begin
					next_r.st = CAOD_IDLE;
					next_r.busy = 1'b0;
					next_r.done = 1'b1;
					next_r.count = '0;
				end else begin
					next_r.count = r.count - 4'h1;
				end
			end
			default: next_r = '0;
		endcase
	end

	// low clk_en holds every field, one-cycle pulses included
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			r <= '0;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	assign dec = r.dec;
	assign dec_valid = r.valid;
	assign dec_illegal = r.illegal;
	assign busy = r.busy;
	assign done = r.done;

endmodule

// *** test/caod_decoder_assertions.sv ***
// checker for caod_decoder: decode fields and state counts
// assumes it is bound to the decoder ports
module caod_decoder_chk
	import caod_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic op_valid,
	input wire logic [7:0] opcode,
	input wire logic cond_instr,
	input wire logic cond_met,
	input caod_dec_s dec,
	input wire logic dec_valid,
	input wire logic dec_illegal,
	input wire logic busy,
	input wire logic done
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	wire t = clk_en && op_valid && !busy && !cond_instr;
	wire a = t && opcode[5:4] != 2'h0;
	sequence s_four;
		dec_valid && dec.states == CYC_REG && clk_en ##1 clk_en[*2];
	endsequence
	property p_reg;
		a && opcode[7:6] == 2'h2 && opcode[2:0] != SEL_MEM
		|=> dec.states == CYC_REG && dec.reg_sel == $past(opcode[2:0]);
	endproperty
	a_reg: assert property (p_reg) else $error("register op decode");
	property p_mem;
		a && opcode[7:6] == 2'h2 && opcode[2:0] == SEL_MEM
		|=> dec.src == CAOD_SRC_MEM && dec.states == CYC_MEM;
	endproperty
	a_mem: assert property (p_mem) else $error("memory op decode");
	property p_imm;
		a && opcode[7:6] == 2'h3 && opcode[2:0] == 3'h6
		|=> dec.src == CAOD_SRC_IMM && dec.states == CYC_MEM;
	endproperty
	a_imm: assert property (p_imm) else $error("immediate op decode");
	property p_pair;
		t && (opcode & OP_PAIR_ADD_MASK) == OP_PAIR_ADD
		|=> dec.states == CYC_PAIR && dec.pair_sel == $past(opcode[5:4]);
	endproperty
	a_pair: assert property (p_pair) else $error("pair add decode");
	property p_rot;
		t && opcode[7:5] == 3'h0 && opcode[2:0] == 3'h7
		|=> dec.states == CYC_REG && dec.reg_sel == SEL_ACC;
	endproperty
	a_rot: assert property (p_rot) else $error("rotate decode");
	property p_cond;
		clk_en && op_valid && !busy && cond_instr
		|=> dec.states == ($past(cond_met) ? CYC_COND_LONG : CYC_COND_SHORT);
	endproperty
	a_cond: assert property (p_cond) else $error("conditional count");
	property p_cmp;
		dec_valid && dec.op == CAOD_CMP |-> dec.writes_flags && !dec.writes_acc;
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare writes acc");
	property p_len;
		s_four |=> done && !busy;
	endproperty
	a_len: assert property (p_len) else $error("four state length");
endmodule
bind caod_decoder caod_decoder_chk chk_u (.mclk, .resetn, .clk_en, .op_valid, .opcode,
	.cond_instr, .cond_met, .dec, .dec_valid, .dec_illegal, .busy, .done);

// *** test/caod_decoder_tb.sv ***
// bench for caod_decoder: offers opcodes back to back, checks decode and length
// assumes the decoder alone; clock enable drops only in the stall scenario
module caod_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import caod_pkg::*;
	logic mclk = 0, resetn = 0, clk_en = 1, op_valid = 0, cond_instr = 0, cond_met = 0;
	logic [7:0] opcode = 8'h00;
	caod_dec_s dec;
	logic dec_valid, dec_illegal, busy, done;
	int bad_count = 0, checks_done = 0, cyc = 0;
	caod_op_e alu_ops[6] = '{CAOD_SUB, CAOD_SBB, CAOD_AND, CAOD_XOR, CAOD_OR, CAOD_CMP};
	caod_op_e rot_ops[4] = '{CAOD_RLC, CAOD_RRC, CAOD_RAL, CAOD_RAR};
	always #25 mclk = ~mclk;
	caod_decoder dut_u (.mclk, .resetn, .clk_en, .op_valid, .opcode, .cond_instr, .cond_met,
		.dec, .dec_valid, .dec_illegal, .busy, .done);
	task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// offer one opcode, return its decode, count states until done
	task automatic go(logic [7:0] op, logic c, logic m, logic [3:0] n, output caod_dec_s d);
		int k;
		{opcode, cond_instr, cond_met, op_valid} = {op, c, m, 1'b1};
		@(posedge mclk) #1;
		op_valid = 0;
		d = dec;
		chk("dec_valid", 8'h01, {7'h0, dec_valid});
		chk("busy", 8'h01, {7'h0, busy});
		k = 1;
		while (done !== 1'b1 && k < 16) begin
			@(posedge mclk) #1;
			k++;
		end
		chk("states", {4'h0, n}, 8'(k));
		chk("busy", 8'h00, {7'h0, busy});
	endtask
	task automatic t_alu();
		caod_dec_s d;
		for (int g = 2; g < 8; g++)
			for (int s = 0; s < 8; s++) begin
				go({2'h2, 3'(g), 3'(s)}, 1'b0, 1'b0, s == 6 ? CYC_MEM : CYC_REG, d);
				chk("reg_sel", 8'(s), {5'h0, d.reg_sel});
				chk("op", 8'(alu_ops[g - 2]), {4'h0, d.op});
				chk("src", 8'(s == 6 ? CAOD_SRC_MEM : CAOD_SRC_REG), {6'h0, d.src});
				chk("use_borrow", 8'(g == 3), {7'h0, d.use_borrow});
				chk("writes_acc", 8'(g != 7), {7'h0, d.writes_acc});
			end
	endtask
	task automatic t_imm();
		caod_dec_s d;
		for (int i = 0; i < 6; i++) begin
			go(8'hd6 + 8'(i * 8), 1'b0, 1'b0, CYC_MEM, d);
			chk("src", 8'(CAOD_SRC_IMM), {6'h0, d.src});
			chk("op", 8'(alu_ops[i]), {4'h0, d.op});
			chk("use_borrow", 8'(i == 1), {7'h0, d.use_borrow});
		end
	endtask
	task automatic t_misc();
		caod_dec_s d;
		for (int p = 0; p < 4; p++) begin
			go({2'h0, 2'(p), 4'h9}, 1'b0, 1'b0, CYC_PAIR, d);
			chk("pair_sel", 8'(p), {6'h0, d.pair_sel});
			chk("op", 8'(CAOD_PAIR_ADD), {4'h0, d.op});
			go({3'h0, 2'(p), 3'h7}, 1'b0, 1'b0, CYC_REG, d);
			chk("op", 8'(rot_ops[p]), {4'h0, d.op});
			chk("reg_sel", 8'(SEL_ACC), {5'h0, d.reg_sel});
		end
		go(8'hc8, 1'b1, 1'b0, CYC_COND_SHORT, d);
		chk("op", 8'(CAOD_COND), {4'h0, d.op});
		go(8'hc8, 1'b1, 1'b1, CYC_COND_LONG, d);
	endtask
	// add register is outside the subset: one illegal pulse, never busy
	task automatic t_bad();
		{opcode, cond_instr, op_valid} = {8'h80, 1'b0, 1'b1};
		@(posedge mclk) #1;
		op_valid = 0;
		chk("dec_illegal", 8'h01, {7'h0, dec_illegal});
		chk("busy", 8'h00, {7'h0, busy});
		@(posedge mclk) #1;
		chk("dec_illegal", 8'h00, {7'h0, dec_illegal});
	endtask
	// clock enable low mid-instruction: states count only enabled cycles
	task automatic t_stall();
		int k;
		{opcode, cond_instr, op_valid} = {8'h90, 1'b0, 1'b1};
		@(posedge mclk) #1;
		op_valid = 0;
		clk_en = 0;
		repeat (3) @(posedge mclk) #1;
		chk("frozen busy", 8'h01, {7'h0, busy});
		chk("frozen dec_valid", 8'h01, {7'h0, dec_valid});
		clk_en = 1;
		k = 1;
		while (done !== 1'b1 && k < 16) begin
			@(posedge mclk) #1;
			k++;
		end
		chk("stalled states", {4'h0, CYC_REG}, 8'(k));
	endtask
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge mclk) if (++cyc == 3000) begin
		bad_count++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge mclk);
		#1 resetn = 1;
		t_alu();
		t_imm();
		t_misc();
		t_bad();
		t_stall();
		print_verdict();
	end
endmodule
